// ### rtl/clock_select_pkg.sv
// Constants, register layouts and types shared by the clock source select logic
package clock_select_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses on the special-function register bus
  localparam logic [7:0] CLOCK_SELECT_ADDR = 8'hA9;
  localparam logic [7:0] SLOW_CTRL_ADDR    = 8'hB1;
  localparam logic [7:0] FAST_TRIM_ADDR    = 8'hC7;

  ////////////////////////////////////////////////////////////////////////////////
  // Source select codes
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_EXT  = 2'h1;
  localparam logic [1:0] SRC_SLOW = 2'h2;

  // Reset values
  localparam logic [1:0] SOURCE_RESET     = 2'h0;
  localparam logic [2:0] POST_DIV_RESET   = 3'h3;
  localparam logic [1:0] SLOW_DIV_RESET   = 2'h0;
  localparam logic [3:0] SLOW_TRIM_RESET  = 4'h0;
  localparam logic [7:0] FAST_TRIM_RESET  = 8'h80;

  // Nominal oscillator rates, for reference by the analog models
  localparam int FAST_OSC_HZ = 24500000;
  localparam int SLOW_OSC_HZ = 80000;

  // Divided slow-oscillator ticks needed before the ready flag rises
  localparam logic [3:0] SLOW_READY_TICKS = 4'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock select register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       rsv7;
    logic [2:0] post_div;
    logic [1:0] rsv3_2;
    logic [1:0] source;
  } clock_sel_t;

  // Slow oscillator control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       enable;
    logic       ready;
    logic [3:0] trim;
    logic [1:0] divider;
  } slow_ctrl_t;

  // Source switch sequencer
  typedef enum logic {SW_RUN, SW_WAIT} switch_state_t;

  // Low mask of a power-of-two divider: shift 0 gives 0, shift 7 gives 7F
  function automatic logic [6:0] div_mask(input logic [2:0] shift);
    div_mask = 7'h7F >> (3'h7 - shift);
  endfunction

endpackage

// ### rtl/edge_sync.sv
// Two-stage synchroniser with a rising-edge pulse behind it
`timescale 1ns/10ps
module edge_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Asynchronous level in
  input  wire logic raw_i,
  // Synchronised level and edge
  output logic      level_o,
  output logic      rise_o
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_stage1;
  logic next_stage2;
  logic next_stage3;

  // Shift chain; only stage2 reads stage1
  always_comb begin
    next_stage1 = raw_i;
    next_stage2 = stage1;
    next_stage3 = stage2;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
    end
  end

  // Edge is taken from the settled stages only
  assign level_o = stage2;
  assign rise_o  = stage2 & ~stage3;

endmodule

// ### rtl/system_clock_source_select.sv
// System clock source selection, post-division and slow oscillator control
//
// What this block does
// - Offers fast internal, slow internal and external pin clock sources.
// - Selected source passes a power-of-two post-divider, one to 128.
// - After reset the fast oscillator is selected with divide by eight.
// - Fast oscillator is enabled whenever it is requested as source.
// - Eight-bit fast trim sets the period; reset value is factory trim.
// - Slow divider codes 00,01,10,11 divide by eight, four, two, one.
// - Four-bit slow trim: zero fastest, all ones slowest.
// - Enable bit 7 runs the slow oscillator; watchdog activity also runs it.
// - Ready flag rises once stable; clears on reset or divider change.
// - In capture mode each divided slow rising edge copies timer 3 count to reload.
// - External pin is resynchronised when clocking peripherals.
// - External pin is the system source only with select code 01.
// - Source may switch on the fly; post-divider writable any time.
// - Internal oscillators usable as source right after their enabling write.
// - Select codes 00 fast, 01 external, 10 slow; 11 reserved.
// - Post-divider field bits 6:4 divides by two to the value; resets 011.
`timescale 1ns/10ps
module system_clock_source_select
  import clock_select_pkg::*;
#(
  parameter logic [7:0] FAST_TRIM_FACTORY = FAST_TRIM_RESET
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Special-function register bus
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  input  wire logic [7:0]  sfr_wdata_i,
  output logic [7:0]       sfr_rdata_o,
  // Raw oscillator and pin clocks
  input  wire logic        fast_internal_osc_i,
  input  wire logic        slow_internal_osc_i,
  input  wire logic        external_clock_pin_i,
  // Oscillator control to the analog cores
  output logic             fast_osc_enable_o,
  output logic [7:0]       fast_osc_trim_o,
  output logic             slow_osc_enable_o,
  output logic [3:0]       slow_osc_trim_o,
  // Watchdog status
  input  wire logic        watchdog_active_i,
  // System clock enable
  output logic             system_clock_tick_o,
  output logic [1:0]       active_source_o,
  output logic             switching_o,
  // External clock for peripherals
  output logic             external_clock_sync_o,
  output logic             external_clock_rise_o,
  // Timer 3 capture hook
  input  wire logic        timer3_capture_mode_i,
  input  wire logic [7:0]  timer3_count_high_i,
  input  wire logic [7:0]  timer3_count_low_i,
  output logic             timer3_capture_o,
  output logic [7:0]       timer3_reload_high_o,
  output logic [7:0]       timer3_reload_low_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  clock_sel_t    clock_select_reg;
  clock_sel_t    next_clock_select_reg;
  slow_ctrl_t    slow_osc_control;
  slow_ctrl_t    next_slow_osc_control;
  logic [7:0]    fast_osc_trim;
  logic [7:0]    next_fast_osc_trim;
  logic [7:0]    rdata;
  logic [7:0]    next_rdata;
  logic [2:0]    slow_div_count;
  logic [2:0]    next_slow_div_count;
  logic [3:0]    ready_count;
  logic [3:0]    next_ready_count;
  logic [6:0]    post_count;
  logic [6:0]    next_post_count;
  logic [1:0]    active_source;
  logic [1:0]    next_active_source;
  switch_state_t sw_state;
  switch_state_t next_sw_state;
  logic          sys_tick;
  logic          next_sys_tick;
  logic          cap_strobe;
  logic          next_cap_strobe;
  logic [7:0]    cap_high;
  logic [7:0]    next_cap_high;
  logic [7:0]    cap_low;
  logic [7:0]    next_cap_low;

  logic          fast_rise;
  logic          slow_rise;
  logic          ext_level;
  logic          ext_rise;
  logic          slow_run;
  logic          slow_tick;
  logic          src_tick;
  logic          wr_select;
  logic          wr_slow;
  logic          wr_trim;
  logic          div_change;
  logic [6:0]    slow_mask;
  logic [6:0]    post_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the three raw clocks
  edge_sync u_fast_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .raw_i   (fast_internal_osc_i),
    .level_o (),
    .rise_o  (fast_rise)
  );

  edge_sync u_slow_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .raw_i   (slow_internal_osc_i),
    .level_o (),
    .rise_o  (slow_rise)
  );

  // External pin passes two flip-flops before any peripheral sees it
  edge_sync u_ext_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .raw_i   (external_clock_pin_i),
    .level_o (ext_level),
    .rise_o  (ext_rise)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode
  assign wr_select  = sfr_wr_i && (sfr_addr_i == CLOCK_SELECT_ADDR);
  assign wr_slow    = sfr_wr_i && (sfr_addr_i == SLOW_CTRL_ADDR);
  assign wr_trim    = sfr_wr_i && (sfr_addr_i == FAST_TRIM_ADDR);
  assign div_change = wr_slow && (sfr_wdata_i[1:0] != slow_osc_control.divider);

  // Register writes; reserved bits keep zero, ready is never written
  always_comb begin
    next_clock_select_reg = clock_select_reg;
    next_slow_osc_control = slow_osc_control;
    next_fast_osc_trim    = fast_osc_trim;
    if (wr_select) begin
      next_clock_select_reg.post_div = sfr_wdata_i[6:4];
      next_clock_select_reg.source   = sfr_wdata_i[1:0];
    end
    if (wr_slow) begin
      next_slow_osc_control.enable  = sfr_wdata_i[7];
      next_slow_osc_control.trim    = sfr_wdata_i[5:2];
      next_slow_osc_control.divider = sfr_wdata_i[1:0];
    end
    if (wr_trim) begin
      next_fast_osc_trim = sfr_wdata_i;
    end
    // A divider change drops ready at once rather than one cycle after the count clears
    next_slow_osc_control.ready = (ready_count == SLOW_READY_TICKS) && !div_change;
  end

  // Read data is registered; unmapped addresses return zero
  always_comb begin
    next_rdata = rdata;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        CLOCK_SELECT_ADDR: next_rdata = clock_select_reg;
        SLOW_CTRL_ADDR:    next_rdata = slow_osc_control;
        FAST_TRIM_ADDR:    next_rdata = fast_osc_trim;
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clock_select_reg <= '{rsv7: 1'b0, post_div: POST_DIV_RESET, rsv3_2: 2'h0, source: SOURCE_RESET};
      slow_osc_control <= '{enable: 1'b0, ready: 1'b0, trim: SLOW_TRIM_RESET, divider: SLOW_DIV_RESET};
      fast_osc_trim    <= FAST_TRIM_FACTORY;
      rdata            <= 8'h00;
    end else begin
      clock_select_reg <= next_clock_select_reg;
      slow_osc_control <= next_slow_osc_control;
      fast_osc_trim    <= next_fast_osc_trim;
      rdata            <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slow oscillator run, output divider and ready qualification
  assign slow_run  = slow_osc_control.enable | watchdog_active_i;
  assign slow_mask = div_mask(3'h3 - {1'b0, slow_osc_control.divider});
  assign slow_tick = slow_run && slow_rise && ((slow_div_count & slow_mask[2:0]) == slow_mask[2:0]);

  // A divider change restarts qualification; that clear beats a same-cycle set
  always_comb begin
    next_slow_div_count = slow_div_count;
    next_ready_count    = ready_count;
    if (slow_run && slow_rise) begin
      next_slow_div_count = slow_div_count + 3'h1;
    end
    if (slow_tick && (ready_count != SLOW_READY_TICKS)) begin
      next_ready_count = ready_count + 4'h1;
    end
    if (div_change) begin
      next_ready_count    = 4'h0;
      next_slow_div_count = 3'h0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slow_div_count <= 3'h0;
      ready_count    <= 4'h0;
    end else begin
      slow_div_count <= next_slow_div_count;
      ready_count    <= next_ready_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source multiplexer; reserved code selects nothing
  always_comb begin
    case (active_source)
      SRC_FAST: src_tick = fast_rise;
      SRC_EXT:  src_tick = ext_rise;
      SRC_SLOW: src_tick = slow_tick;
      default:  src_tick = 1'b0;
    endcase
  end

  // Glitch-free switch: hold output low, then start on the new source's first edge
  always_comb begin
    next_sw_state      = sw_state;
    next_active_source = active_source;
    next_post_count    = post_count;
    next_sys_tick      = 1'b0;
    post_mask          = div_mask(clock_select_reg.post_div);
    case (sw_state)
      SW_RUN: begin
        if (clock_select_reg.source != active_source) begin
          next_sw_state      = SW_WAIT;
          next_active_source = clock_select_reg.source;
          next_post_count    = 7'h00;
        end else if (src_tick) begin
          next_post_count = post_count + 7'h01;
          next_sys_tick   = ((post_count & post_mask) == post_mask);
        end
      end
      SW_WAIT: begin
        if (clock_select_reg.source != active_source) begin
          next_active_source = clock_select_reg.source;
        end else if (src_tick) begin
          next_sw_state   = SW_RUN;
          next_post_count = 7'h01;
          next_sys_tick   = (post_mask == 7'h00);
        end
      end
      default: begin
        next_sw_state = SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_state      <= SW_RUN;
      active_source <= SOURCE_RESET;
      post_count    <= 7'h00;
      sys_tick      <= 1'b0;
    end else begin
      sw_state      <= next_sw_state;
      active_source <= next_active_source;
      post_count    <= next_post_count;
      sys_tick      <= next_sys_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer 3 capture on each divided slow-oscillator rising edge
  always_comb begin
    next_cap_strobe = 1'b0;
    next_cap_high   = cap_high;
    next_cap_low    = cap_low;
    if (timer3_capture_mode_i && slow_tick) begin
      next_cap_strobe = 1'b1;
      next_cap_high   = timer3_count_high_i;
      next_cap_low    = timer3_count_low_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_strobe <= 1'b0;
      cap_high   <= 8'h00;
      cap_low    <= 8'h00;
    end else begin
      cap_strobe <= next_cap_strobe;
      cap_high   <= next_cap_high;
      cap_low    <= next_cap_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Fast core runs while requested or while it is still the active source
  assign fast_osc_enable_o     = (clock_select_reg.source == SRC_FAST) || (active_source == SRC_FAST);
  assign fast_osc_trim_o       = fast_osc_trim;
  assign slow_osc_enable_o     = slow_run;
  assign slow_osc_trim_o       = slow_osc_control.trim;
  assign sfr_rdata_o           = rdata;
  assign system_clock_tick_o   = sys_tick;
  assign active_source_o       = active_source;
  assign switching_o           = (sw_state == SW_WAIT);
  assign external_clock_sync_o = ext_level;
  assign external_clock_rise_o = ext_rise;
  assign timer3_capture_o      = cap_strobe;
  assign timer3_reload_high_o  = cap_high;
  assign timer3_reload_low_o   = cap_low;

endmodule

// ### sim/clock_select_properties.sv
// Port-level assertions for the system clock source select block
`timescale 1ns/10ps
module clock_select_properties
  import clock_select_pkg::*;
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       nrst_i,
  // Register read side
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  // Oscillator enables and source
  input wire logic       watchdog_active_i,
  input wire logic       fast_osc_enable_o,
  input wire logic       slow_osc_enable_o,
  input wire logic       system_clock_tick_o,
  input wire logic [1:0] active_source_o,
  input wire logic       switching_o,
  // External pin path
  input wire logic       external_clock_pin_i,
  input wire logic       external_clock_sync_o,
  input wire logic       external_clock_rise_o,
  // Timer 3 capture
  input wire logic       timer3_capture_mode_i,
  input wire logic [7:0] timer3_count_high_i,
  input wire logic [7:0] timer3_count_low_i,
  input wire logic       timer3_capture_o,
  input wire logic [7:0] timer3_reload_high_o,
  input wire logic [7:0] timer3_reload_low_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin seen low, then high, on two sampling edges
  sequence seq_pin_rise;
    !external_clock_pin_i ##1 external_clock_pin_i;
  endsequence
  // Two flops later the synced level must rise, never sooner: a single flop risks metastability
  sequence seq_sync_rise;
    ##2 $rose(external_clock_sync_o);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus, enables, clock path and capture hook
  AST_RDATA_HOLDS: assert property (!$past(sfr_rd_i) |-> $stable(sfr_rdata_o))
    else $error("read data changed without a read");
  AST_FAST_REQUESTED: assert property (active_source_o == SRC_FAST |-> fast_osc_enable_o)
    else $error("fast oscillator off while it is the source");
  AST_WATCHDOG_SLOW: assert property (watchdog_active_i |-> slow_osc_enable_o)
    else $error("slow oscillator off while watchdog active");
  AST_TICK_PULSE: assert property (system_clock_tick_o |=> !system_clock_tick_o)
    else $error("system clock tick longer than one cycle");
  AST_SWITCH_QUIET: assert property (switching_o && $past(switching_o) |-> !system_clock_tick_o)
    else $error("tick issued while switching source");
  AST_SWITCH_ENDS: assert property ($rose(switching_o) && active_source_o != 2'h3 |-> ##[1:1000] !switching_o)
    else $error("source switch never completed");
  AST_SYNC_CHAIN: assert property (seq_pin_rise |-> seq_sync_rise)
    else $error("external pin not synchronised through two stages");
  AST_SYNC_RISE: assert property ($rose(external_clock_sync_o) |-> ##[0:1] external_clock_rise_o)
    else $error("no rise pulse for synced external edge");
  AST_CAPTURE_COPY: assert property (timer3_capture_o |-> $past(timer3_capture_mode_i) &&
    timer3_reload_high_o == $past(timer3_count_high_i) && timer3_reload_low_o == $past(timer3_count_low_i))
    else $error("capture did not copy the timer count");
  AST_RELOAD_HOLDS: assert property (!timer3_capture_o |-> $stable(timer3_reload_high_o) &&
    $stable(timer3_reload_low_o))
    else $error("reload changed without a capture");
endmodule

bind system_clock_source_select clock_select_properties props (.*);

// ### sim/tb_top.sv
// Self-checking bench for the system clock source select block
`timescale 1ns/10ps
module tb_top;
  import clock_select_pkg::*;
  logic       clk_i, nrst_i, sfr_wr_i, sfr_rd_i, watchdog_active_i, timer3_capture_mode_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, fast_osc_trim_o, trim_val;
  logic [7:0] timer3_count_high_i = 8'h00, timer3_count_low_i = 8'h00;
  logic       fast_internal_osc_i = 1'b0, slow_internal_osc_i = 1'b0, external_clock_pin_i = 1'b0;
  logic       fast_osc_enable_o;
  logic       slow_osc_enable_o, system_clock_tick_o, switching_o, external_clock_sync_o;
  logic       external_clock_rise_o, timer3_capture_o;
  logic [3:0] slow_osc_trim_o;
  logic [1:0] active_source_o;
  logic [7:0] timer3_reload_high_o, timer3_reload_low_o;
  logic [15:0] prev_cnt;
  logic [7:0] exp_q[$];
  logic       rd_seen;
  int         seed = 32'h48a5;
  int         rnd, n, cyc = 0, captures = 0, mismatches = 0, total_checks = 0;

  system_clock_source_select dut (.*);

  ////////////////////////////////////////////////////////////////////////////////
  // System clock, 50 MHz
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Raw sources: fast period 4, slow period 10, pin period 6 cycles; random timer count
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    fast_internal_osc_i <= cyc[1];
    if (cyc % 5 == 0) slow_internal_osc_i <= ~slow_internal_osc_i;
    if (cyc % 3 == 0) external_clock_pin_i <= ~external_clock_pin_i;
    rnd = $random(seed);
    {timer3_count_high_i, timer3_count_low_i} <= rnd[15:0];
  end

  // Result watcher: read data one cycle after the strobe, reload on each capture
  always @(posedge clk_i) begin
    rd_seen <= sfr_rd_i && nrst_i;
    prev_cnt <= {timer3_count_high_i, timer3_count_low_i};
    if (rd_seen) chk("sfr_rdata_o", {8'h00, exp_q.pop_front()}, {8'h00, sfr_rdata_o});
    if (timer3_capture_o) captures++;
    if (timer3_capture_o) chk("reload", prev_cnt, {timer3_reload_high_o, timer3_reload_low_o});
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and timing helpers
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    // Let the write land before anyone looks at the outputs
    @(posedge clk_i);
  endtask
  // Note the expectation, then strobe; the watcher compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    exp_q.push_back(e);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (!(system_clock_tick_o === 1'b1) && k < 3000);
    if (k >= 3000) chk("tick wait", 16'h1, 16'h0);
    if (k >= 3000) give_verdict();
  endtask
  // Skip two ticks so a switch or divider change has settled, then time one gap
  task automatic measure(input int exp);
    int k;
    wait_tick(k);
    wait_tick(k);
    wait_tick(k);
    chk("tick period", 16'(exp), 16'(k));
  endtask
  task automatic wait_src(input logic [1:0] s);
    int k;
    for (k = 0; k < 2000 && !(active_source_o === s && switching_o === 1'b0); k++) @(posedge clk_i);
    chk("active_source_o", {14'h0, s}, {14'h0, active_source_o});
    if (k >= 2000) chk("source wait", 16'h1, 16'h0);
    if (k >= 2000) give_verdict();
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {nrst_i, sfr_wr_i, sfr_rd_i, watchdog_active_i, timer3_capture_mode_i} = '0;
    {sfr_addr_i, sfr_wdata_i} = '0;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(CLOCK_SELECT_ADDR, 8'h30);
    rd(SLOW_CTRL_ADDR, 8'h00);
    rd(FAST_TRIM_ADDR, FAST_TRIM_RESET);
    rd(8'h00, 8'h00);
    chk("fast_osc_enable_o", 16'h1, {15'h0, fast_osc_enable_o});
    measure(32);
    // Own copy of the random trim: the source process keeps overwriting rnd
    trim_val = 8'($random(seed));
    wr(FAST_TRIM_ADDR, trim_val);
    rd(FAST_TRIM_ADDR, trim_val);
    chk("fast_osc_trim_o", {8'h00, trim_val}, {8'h00, fast_osc_trim_o});
    for (int d = 0; d < 8; d++) begin
      wr(CLOCK_SELECT_ADDR, {1'b0, 3'(d), 4'h0});
      rd(CLOCK_SELECT_ADDR, {1'b0, 3'(d), 4'h0});
      measure(4 << d);
    end
    watchdog_active_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("slow_osc_enable_o", 16'h1, {15'h0, slow_osc_enable_o});
    watchdog_active_i <= 1'b0;
    // Trim is set while the slow oscillator is still off
    wr(SLOW_CTRL_ADDR, 8'h3F);
    wr(SLOW_CTRL_ADDR, 8'hFF);
    chk("slow_osc_trim_o", 16'hF, {12'h0, slow_osc_trim_o});
    chk("slow_osc_enable_o", 16'h1, {15'h0, slow_osc_enable_o});
    rd(SLOW_CTRL_ADDR, 8'hBF);
    repeat (120) @(posedge clk_i);
    rd(SLOW_CTRL_ADDR, 8'hFF);
    wr(CLOCK_SELECT_ADDR, {6'h00, SRC_SLOW});
    wait_src(SRC_SLOW);
    chk("fast_osc_enable_o", 16'h0, {15'h0, fast_osc_enable_o});
    timer3_capture_mode_i <= 1'b1;
    measure(10);
    for (int c = 2; c >= 0; c--) begin
      wr(SLOW_CTRL_ADDR, 8'hBC | 8'(c));
      rd(SLOW_CTRL_ADDR, 8'hBC | 8'(c));
      measure(10 << (3 - c));
    end
    timer3_capture_mode_i <= 1'b0;
    chk("captures", 16'h1, 16'(captures > 0));
    wr(CLOCK_SELECT_ADDR, {6'h00, SRC_EXT});
    wait_src(SRC_EXT);
    measure(6);
    wr(CLOCK_SELECT_ADDR, 8'hFF);
    rd(CLOCK_SELECT_ADDR, 8'h73);
    repeat (10) @(posedge clk_i);
    n = 0;
    repeat (300) begin
      @(posedge clk_i);
      if (system_clock_tick_o !== 1'b0) n++;
    end
    chk("reserved select ticks", 16'h0, 16'(n));
    wr(CLOCK_SELECT_ADDR, 8'h00);
    wait_src(SRC_FAST);
    chk("fast_osc_enable_o", 16'h1, {15'h0, fast_osc_enable_o});
    measure(4);
    // Reset again in mid-run; defaults must come back
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(CLOCK_SELECT_ADDR, 8'h30);
    measure(32);
    give_verdict();
  end
endmodule
